// ---- fault_aggregator.sv ----
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module fault_aggregator
   import fault_aggregator_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // error sources
   input  wire low_src_type         low_src,
   input  wire logic [MID_CH-1:0]   mid_src,
   input  wire logic [HIGH_CH-1:0]  high_src,
   // outputs to system and monitor
   output logic                     irq_low_r,
   output logic                     irq_high_r,
   output logic                     fault_pin_n_r,
   // axi4-lite write
   input  wire logic [7:0]          awaddr,
   input  wire logic                awvalid,
   output logic                     awready_r,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready_r,
   output logic [1:0]               bresp_r,
   output logic                     bvalid_r,
   input  wire logic                bready,
   // axi4-lite read
   input  wire logic [7:0]          araddr,
   input  wire logic                arvalid,
   output logic                     arready_r,
   output logic [31:0]              rdata_r,
   output logic [1:0]               rresp_r,
   output logic                     rvalid_r,
   input  wire logic                rready
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic [63:0] rise(input logic [63:0] cur,
                                        input logic [63:0] prev);
      return cur & ~prev;
   endfunction : rise

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [63:0]    low_vec;
   logic [63:0]    low_prev_r;
   logic [31:0]    mid_prev_r;
   logic [31:0]    high_prev_r;
   logic [63:0]    low_stat_r;
   logic [31:0]    mid_stat_r;
   logic [31:0]    high_stat_r;
   logic [63:0]    low_inten_r;
   logic [63:0]    low_prio_r;
   logic [63:0]    low_pinen_r;
   pin_time_type   time_r;
   logic           force_r;
   logic [7:0]     aw_addr_r;
   logic [31:0]    w_data_r;
   logic [3:0]     w_strb_r;
   logic           wr_fire;
   logic [31:0]    wr_bits;
   logic [63:0]    low_clr;
   logic [31:0]    mid_clr;
   logic [31:0]    high_clr;
   logic           cause;
   pin_state_type  pin_state_r;
   pin_state_type  pin_state_nxt;
   logic [15:0]    presc_cnt_r;
   logic [15:0]    hold_cnt_r;
   logic           tick;
   logic [63:0]    mid_rise;
   logic [63:0]    high_rise;

   // reserved channels never reach the flags
   assign low_vec = low_src
                    & ~LOW_RESERVED;
   assign mid_rise  = rise({32'h0, mid_src}, {32'h0, mid_prev_r});
   assign high_rise = rise({32'h0, high_src}, {32'h0, high_prev_r});

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   // address and data are taken independently; ready low means held
   assign wr_fire = !awready_r && !wready_r && !bvalid_r;
   assign wr_bits = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            case (aw_addr_r)
               LOW_CLR_LO, LOW_CLR_HI, LOW_INTEN_LO, LOW_INTEN_HI,
               LOW_PRIO_LO, LOW_PRIO_HI, LOW_PINEN_LO, LOW_PINEN_HI,
               MID_CLR, HIGH_CLR, PIN_TIME, PIN_CTRL: begin
                  bresp_r <= RESP_OKAY;
               end
               default: begin
                  bresp_r <= RESP_SLVERR;
               end
            endcase
         end
         if (bvalid_r && bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // clear pulses from the write-only clear registers
   always_comb begin
      low_clr  = 64'h0;
      mid_clr  = 32'h0;
      high_clr = 32'h0;
      if (wr_fire) begin
         case (aw_addr_r)
            LOW_CLR_LO: low_clr[31:0]  = wr_bits;
            LOW_CLR_HI: low_clr[63:32] = wr_bits;
            MID_CLR:    mid_clr        = wr_bits;
            HIGH_CLR:   high_clr       = wr_bits;
            default:    low_clr        = 64'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_inten_r <= 64'h0;
         low_prio_r  <= 64'h0;
         low_pinen_r <= 64'h0;
         time_r      <= '{presc: PRESC_RST, hold: HOLD_RST};
         force_r     <= 1'b0;
      end else if (wr_fire) begin
         case (aw_addr_r)
            LOW_INTEN_LO: low_inten_r[31:0]  <= merge(low_inten_r[31:0],
                                                      w_data_r, w_strb_r);
            LOW_INTEN_HI: low_inten_r[63:32] <= merge(low_inten_r[63:32],
                                                      w_data_r, w_strb_r);
            LOW_PRIO_LO:  low_prio_r[31:0]   <= merge(low_prio_r[31:0],
                                                      w_data_r, w_strb_r);
            LOW_PRIO_HI:  low_prio_r[63:32]  <= merge(low_prio_r[63:32],
                                                      w_data_r, w_strb_r);
            LOW_PINEN_LO: low_pinen_r[31:0]  <= merge(low_pinen_r[31:0],
                                                      w_data_r, w_strb_r);
            LOW_PINEN_HI: low_pinen_r[63:32] <= merge(low_pinen_r[63:32],
                                                      w_data_r, w_strb_r);
            PIN_TIME:     time_r <= pin_time_type'(merge(time_r,
                                                      w_data_r, w_strb_r));
            PIN_CTRL:     if (w_strb_r[0]) begin
               force_r <= w_data_r[FORCE_BIT];
            end
            default:      force_r <= force_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------
   // set wins over a clear landing in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_prev_r  <= 64'h0;
         mid_prev_r  <= 32'h0;
         high_prev_r <= 32'h0;
         low_stat_r  <= 64'h0;
         mid_stat_r  <= 32'h0;
         high_stat_r <= 32'h0;
      end else begin
         low_prev_r  <= low_vec;
         mid_prev_r  <= mid_src;
         high_prev_r <= high_src;
         low_stat_r  <= (low_stat_r & ~low_clr)
                        | rise(low_vec, low_prev_r);
         mid_stat_r  <= (mid_stat_r & ~mid_clr)
                        | mid_rise[31:0];
         high_stat_r <= (high_stat_r & ~high_clr)
                        | high_rise[31:0];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // the high group never reaches either line
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_low_r  <= 1'b0;
         irq_high_r <= 1'b0;
      end else begin
         irq_low_r  <= |(low_stat_r & low_inten_r & ~low_prio_r);
         irq_high_r <= |(low_stat_r & low_inten_r & low_prio_r)
                       | (|mid_stat_r);
      end
   end

   // ----------------------------------------------------------------
   // fault pin and its time base
   // ----------------------------------------------------------------
   assign cause = |(low_stat_r & low_pinen_r)
                  | (|mid_stat_r) | (|high_stat_r)
                  | force_r;
   assign tick  = (presc_cnt_r == 16'h0000);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc_cnt_r <= PRESC_RST;
      end else if (tick) begin
         presc_cnt_r <= time_r.presc;
      end else begin
         presc_cnt_r <= presc_cnt_r - 16'h0001;
      end
   end

   always_comb begin
      pin_state_nxt = pin_state_r;
      case (pin_state_r)
         PIN_OK: begin
            if (cause) begin
               pin_state_nxt = PIN_FAULT;
            end
         end
         PIN_FAULT: begin
            if (!cause) begin
               pin_state_nxt = PIN_HOLD;
            end
         end
         PIN_HOLD: begin
            if (cause) begin
               pin_state_nxt = PIN_FAULT;
            end else if (hold_cnt_r == 16'h0000) begin
               pin_state_nxt = PIN_OK;
            end
         end
         default: pin_state_nxt = PIN_OK;
      endcase
   end

   // pin leaves the low level only after the hold ticks have run out
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_state_r   <= PIN_OK;
         hold_cnt_r    <= 16'h0000;
         fault_pin_n_r <= 1'b1;
      end else begin
         pin_state_r   <= pin_state_nxt;
         fault_pin_n_r <= (pin_state_nxt == PIN_OK);
         if (pin_state_nxt == PIN_FAULT) begin
            hold_cnt_r <= time_r.hold;
         end else if (tick && hold_cnt_r != 16'h0000) begin
            hold_cnt_r <= hold_cnt_r - 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else begin
         if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
            case (araddr)
               LOW_STAT_LO:  rdata_r <= low_stat_r[31:0];
               LOW_STAT_HI:  rdata_r <= low_stat_r[63:32];
               LOW_INTEN_LO: rdata_r <= low_inten_r[31:0];
               LOW_INTEN_HI: rdata_r <= low_inten_r[63:32];
               LOW_PRIO_LO:  rdata_r <= low_prio_r[31:0];
               LOW_PRIO_HI:  rdata_r <= low_prio_r[63:32];
               LOW_PINEN_LO: rdata_r <= low_pinen_r[31:0];
               LOW_PINEN_HI: rdata_r <= low_pinen_r[63:32];
               MID_STAT:     rdata_r <= mid_stat_r;
               HIGH_STAT:    rdata_r <= high_stat_r;
               PIN_TIME:     rdata_r <= time_r;
               PIN_CTRL:     rdata_r <= {31'h0, force_r};
               PIN_STAT:     rdata_r <= {30'h0, pin_state_r == PIN_HOLD,
                                         !fault_pin_n_r};
               LOW_CLR_LO, LOW_CLR_HI, MID_CLR, HIGH_CLR: begin
                  rdata_r <= 32'h0000_0000;
               end
               default:      rresp_r <= RESP_SLVERR;
            endcase
         end
         if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_reserved_quiet: assert property (
      (low_stat_r & LOW_RESERVED) == 64'h0)
      else $error("reserved channel flag set");
   a_rise_latch: assert property (
      $rose(low_vec[2]) |=> low_stat_r[2])
      else $error("rising input not latched");
   a_flag_sticky: assert property (
      low_stat_r[6] && !low_clr[6] |=> low_stat_r[6])
      else $error("flag dropped without clear");
   a_mid_irq_high: assert property (|mid_stat_r |=> irq_high_r)
      else $error("mid group missed high irq");
   a_high_no_irq: assert property (
      low_stat_r == 64'h0 && mid_stat_r == 32'h0
      |=> !irq_low_r && !irq_high_r)
      else $error("irq without low or mid flag");
   a_low_route: assert property (
      |(low_stat_r & low_inten_r & ~low_prio_r) |=> irq_low_r)
      else $error("low route irq missing");
   a_high_pin: assert property (|high_stat_r |=> !fault_pin_n_r)
      else $error("high flag did not drive pin");
   a_force_pin: assert property ($rose(force_r) |=> !fault_pin_n_r)
      else $error("forced pin not low");
   a_hold_low: assert property (
      pin_state_r == PIN_HOLD && hold_cnt_r != 16'h0000 |=> !fault_pin_n_r)
      else $error("pin released during hold");
   a_mask_pin: assert property (!cause && pin_state_r == PIN_OK
                                |=> fault_pin_n_r)
      else $error("pin low without cause");

   c_force_cycle: cover property (force_r ##1 !force_r [*2] ##1 fault_pin_n_r);
   c_hold_done: cover property (pin_state_r == PIN_HOLD
                                ##1 pin_state_r == PIN_OK);
   c_low_irq: cover property ($rose(irq_low_r));
   c_mid_flag: cover property ($rose(|mid_stat_r));

endmodule : fault_aggregator

// ---- fault_aggregator_pkg.sv ----
package fault_aggregator_pkg;

   // ----------------------------------------------------------------
   // channel counts and tied-off channels
   // ----------------------------------------------------------------
   localparam int          LOW_CH       = 64;
   localparam int          MID_CH       = 32;
   localparam int          HIGH_CH      = 32;
   localparam logic [63:0] LOW_RESERVED = 64'h0000_0000_0001_5011;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] LOW_STAT_LO  = 8'h00;
   localparam logic [7:0] LOW_STAT_HI  = 8'h04;
   localparam logic [7:0] LOW_CLR_LO   = 8'h08;
   localparam logic [7:0] LOW_CLR_HI   = 8'h0C;
   localparam logic [7:0] LOW_INTEN_LO = 8'h10;
   localparam logic [7:0] LOW_INTEN_HI = 8'h14;
   localparam logic [7:0] LOW_PRIO_LO  = 8'h18;
   localparam logic [7:0] LOW_PRIO_HI  = 8'h1C;
   localparam logic [7:0] LOW_PINEN_LO = 8'h20;
   localparam logic [7:0] LOW_PINEN_HI = 8'h24;
   localparam logic [7:0] MID_STAT     = 8'h28;
   localparam logic [7:0] MID_CLR      = 8'h2C;
   localparam logic [7:0] HIGH_STAT    = 8'h30;
   localparam logic [7:0] HIGH_CLR     = 8'h34;
   localparam logic [7:0] PIN_TIME     = 8'h38;
   localparam logic [7:0] PIN_CTRL     = 8'h3C;
   localparam logic [7:0] PIN_STAT     = 8'h40;

   // ----------------------------------------------------------------
   // reset values, field positions, responses
   // ----------------------------------------------------------------
   localparam logic [15:0] HOLD_RST   = 16'h0010;
   localparam logic [15:0] PRESC_RST  = 16'h0003;
   localparam int          FORCE_BIT  = 0;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [63:17] other;
      logic         rsv16;
      logic         ivu_parity;
      logic         rsv14;
      logic         xfer_wr_err;
      logic         rsv12;
      logic         osc_fail;
      logic         pll_slip;
      logic         tu_mpu_viol;
      logic         tu_pkt_parity;
      logic         timer_ram_parity;
      logic         flash_ecc_corr;
      logic         xfer_rd_err;
      logic         rsv4;
      logic         xfer_pkt_parity;
      logic         xfer_mpu_viol;
      logic         conv2_parity;
      logic         rsv0;
   } low_src_type;

   typedef struct packed {
      logic [15:0] presc;
      logic [15:0] hold;
   } pin_time_type;

   typedef enum logic [1:0] {PIN_OK, PIN_FAULT, PIN_HOLD} pin_state_type;

endpackage : fault_aggregator_pkg

// ---- fault_aggregator_test.sv ----
`timescale 1ns/10ps
module fault_aggregator_test;
   import fault_aggregator_pkg::*;
   logic        clk, nrst, irq_low_r, irq_high_r, fault_pin_n_r;
   low_src_type low_src;
   logic [31:0] mid_src, high_src, wdata, rdata_r;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready_r, wvalid, wready_r, bvalid_r, bready;
   logic        arvalid, arready_r, rvalid_r, rready;
   logic [3:0]  wstrb, strb;
   logic [1:0]  bresp_r, rresp_r;
   int          n_fail, checked, n_pulses, low_len, n;
   int          chans [12] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 13, 15};

   fault_aggregator dut (.clk(clk), .nrst(nrst), .low_src(low_src),
      .mid_src(mid_src), .high_src(high_src), .irq_low_r(irq_low_r),
      .irq_high_r(irq_high_r), .fault_pin_n_r(fault_pin_n_r),
      .awaddr(awaddr), .awvalid(awvalid), .awready_r(awready_r),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready_r(wready_r),
      .bresp_r(bresp_r), .bvalid_r(bvalid_r), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready_r(arready_r),
      .rdata_r(rdata_r), .rresp_r(rresp_r), .rvalid_r(rvalid_r),
      .rready(rready));
   pin_monitor mon (.clk(clk), .nrst(nrst), .fault_pin_n(fault_pin_n_r),
      .n_pulses(n_pulses), .low_len(low_len));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task chk_rng(input string name, input int lo, input int hi, input int g);
      checked++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, g);
      end
   endtask : chk_rng

   // ----------------------------------------------------------------
   // bus master: hits are sampled mid-cycle, acted on at the next edge
   // ----------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_hit, w_hit, b_hit;
      logic [1:0] r;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= strb;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      b_hit = 1'b0;
      while (!b_hit) begin
         @(negedge clk);
         aw_hit = awvalid & awready_r;
         w_hit  = wvalid & wready_r;
         b_hit  = bvalid_r;
         r      = bresp_r;
         @(posedge clk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         if (b_hit) bready <= 1'b0;
      end
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar_hit, r_hit;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      r_hit = 1'b0;
      while (!r_hit) begin
         @(negedge clk);
         ar_hit = arvalid & arready_r;
         r_hit  = rvalid_r;
         d      = rdata_r;
         r      = rresp_r;
         @(posedge clk);
         if (ar_hit) arvalid <= 1'b0;
         if (r_hit) rready <= 1'b0;
      end
      chk("rdata", ed, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rd

   task see(input logic il, input logic ih, input logic pn);
      @(negedge clk);
      chk("irq_low", {31'h0, il}, {31'h0, irq_low_r});
      chk("irq_high", {31'h0, ih}, {31'h0, irq_high_r});
      chk("fault_pin_n", {31'h0, pn}, {31'h0, fault_pin_n_r});
   endtask : see

   // the default hold is 16 ticks of 4 clocks, so 80 cycles covers it
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end

   initial begin
      {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, mid_src, high_src} = '0;
      low_src = '0;
      strb = 4'hF;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(PIN_TIME, {PRESC_RST, HOLD_RST}, RESP_OKAY);
      see(1'b0, 1'b0, 1'b1);
      wr(LOW_INTEN_LO, 32'hFFFFFFFF, RESP_OKAY);
      wr(LOW_INTEN_HI, 32'hFFFFFFFF, RESP_OKAY);
      low_src <= low_src_type'(LOW_RESERVED);
      repeat (4) @(posedge clk);
      low_src <= '0;
      rd(LOW_STAT_LO, 32'h0, RESP_OKAY);
      see(1'b0, 1'b0, 1'b1);
      foreach (chans[i]) begin
         low_src <= low_src_type'(64'h1 << chans[i]);
         repeat (4) @(posedge clk);
         low_src <= '0;
         repeat (2) @(posedge clk);
         rd(LOW_STAT_LO, 32'h1 << chans[i],
            RESP_OKAY);
         see(1'b1, 1'b0, 1'b1);
         wr(LOW_CLR_LO, 32'h1 << chans[i], RESP_OKAY);
         repeat (2) @(posedge clk);
         see(1'b0, 1'b0, 1'b1);
      end
      wr(LOW_PRIO_HI, 32'h00000100, RESP_OKAY);
      wr(LOW_PINEN_HI, 32'h00000100, RESP_OKAY);
      low_src <= low_src_type'(64'h1 << 40);
      repeat (4) @(posedge clk);
      low_src <= '0;
      see(1'b0, 1'b1, 1'b0);
      wr(LOW_INTEN_HI, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clk);
      see(1'b0, 1'b0, 1'b0);
      rd(LOW_STAT_HI, 32'h00000100, RESP_OKAY);
      wr(LOW_CLR_HI, 32'h00000100, RESP_OKAY);
      repeat (80) @(posedge clk);
      see(1'b0, 1'b0, 1'b1);
      // two different sources of one group must behave alike
      mid_src <= 32'h80000001;
      repeat (4) @(posedge clk);
      mid_src <= '0;
      see(1'b0, 1'b1, 1'b0);
      rd(MID_STAT, 32'h80000001, RESP_OKAY);
      wr(MID_CLR, 32'h80000001, RESP_OKAY);
      repeat (80) @(posedge clk);
      see(1'b0, 1'b0, 1'b1);
      high_src <= 32'h80000000;
      repeat (4) @(posedge clk);
      high_src <= '0;
      see(1'b0, 1'b0, 1'b0);
      rd(HIGH_STAT, 32'h80000000, RESP_OKAY);
      wr(HIGH_CLR, 32'h80000000, RESP_OKAY);
      repeat (80) @(posedge clk);
      see(1'b0, 1'b0, 1'b1);
      wr(PIN_TIME, 32'h00010004, RESP_OKAY);
      wr(PIN_CTRL, 32'h1, RESP_OKAY);
      repeat (4) @(posedge clk);
      see(1'b0, 1'b0, 1'b0);
      rd(PIN_STAT, 32'h1, RESP_OKAY);
      wr(PIN_CTRL, 32'h0, RESP_OKAY);
      n = 0;
      while (fault_pin_n_r !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk_rng("hold", 5, 12, n);
      // the monitor counts a pulse one edge after the pin goes high
      @(negedge clk);
      chk("pulses", 32'h4, n_pulses);
      // about ten forced cycles plus four ticks of two clocks
      chk_rng("low_len", 14, 22, low_len);
      strb = 4'h2;
      wr(LOW_PINEN_LO, 32'hFFFFFFFF, RESP_OKAY);
      strb = 4'hF;
      rd(LOW_PINEN_LO, 32'h0000FF00, RESP_OKAY);
      wr(8'h44, 32'h1, RESP_SLVERR);
      rd(8'h44, 32'h0, RESP_SLVERR);
      wr(LOW_STAT_LO, 32'hFFFF, RESP_SLVERR);
      rd(LOW_CLR_LO, 32'h0, RESP_OKAY);
      end_of_test();
   end
endmodule : fault_aggregator_test

// ---- pin_monitor.sv ----
`timescale 1ns/10ps
module pin_monitor (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // watched pin
   input  wire logic fault_pin_n,
   // what the monitor saw
   output int        n_pulses,
   output int        low_len
);
   int run;

   // ----------------------------------------------------------------
   // measure every low interval, as an outside safety circuit would
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run      <= 0;
         n_pulses <= 0;
         low_len  <= 0;
      end else if (fault_pin_n === 1'b0) begin
         run <= run + 1;
      end else if (run != 0) begin
         low_len  <= run;
         n_pulses <= n_pulses + 1;
         run      <= 0;
      end
   end
endmodule : pin_monitor
